// [src/aph_pkg.sv]
// Shared constants and types for the absolute position handshake readout
package aph_pkg;
	localparam int unsigned CLK_HZ      = 50_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	// Times in ms; settle and confirm are not fixed by the link, plain defaults
	localparam int unsigned SETTLE_MS   = 10;
	localparam int unsigned PREP_MIN_MS = 5 + 2;
	localparam int unsigned PREP_MAX_MS = 5 + 10;
	localparam int unsigned CONFIRM_MS  = 2;
	localparam int unsigned TIMEOUT_MS  = 5000;
	localparam int unsigned HSETTLE_MS  = 12;
	localparam int unsigned SETTLE_CYC  = SETTLE_MS * CYC_PER_MS;
	localparam int unsigned PREP_CYC    = PREP_MIN_MS * CYC_PER_MS;
	localparam int unsigned HCLR_CYC    = PREP_MAX_MS * CYC_PER_MS;
	localparam int unsigned CONFIRM_CYC = CONFIRM_MS * CYC_PER_MS;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
	localparam int unsigned HSETTLE_CYC = HSETTLE_MS * CYC_PER_MS;
	localparam int unsigned DROP_CYC    = 8;
	// Frame layout
	localparam int unsigned FRAME_BITS  = 80;
	localparam int unsigned STAT_LSB    = 0;
	localparam int unsigned TURN_LSB    = 16;
	localparam int unsigned PULSE_LSB   = 32;
	localparam int unsigned CKSUM_LSB   = 64;
	localparam logic [15:0] CK_K0       = 16'hA700;
	localparam logic [15:0] CK_K1       = 16'h605A;
	localparam logic [15:0] CK_K2       = 16'h30A5;
	localparam logic [15:0] CK_K3       = 16'h5A06;
	localparam logic [15:0] COORD_INIT_VAL = 16'h0001;
	// Host register map
	localparam int unsigned ADDR_W      = 8;
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_STAT    = 8'h04;
	localparam logic [7:0]  REG_DATA0   = 8'h08;
	localparam logic [7:0]  REG_DATA1   = 8'h0C;
	localparam logic [7:0]  REG_DATA2   = 8'h10;
	localparam int unsigned CTRL_READ   = 0;
	localparam int unsigned CTRL_CLEAR  = 1;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [6:0] {
		D_IDLE    = 7'h01,
		D_SETTLE  = 7'h02,
		D_WAIT    = 7'h04,
		D_PREP    = 7'h08,
		D_READY   = 7'h10,
		D_CONFIRM = 7'h20,
		D_HOLD    = 7'h40
	} aph_dev_state_t;

	typedef enum logic [5:0] {
		H_IDLE    = 6'h01,
		H_SETTLE  = 6'h02,
		H_REQ     = 6'h04,
		H_WAITLOW = 6'h08,
		H_CLEAR   = 6'h10,
		H_DROP    = 6'h20
	} aph_host_state_t;
endpackage : aph_pkg

// [src/aph_link_if.sv]
// Discrete handshake wires between host controller and drive
`timescale 1ns/1ps
interface aph_link_if;
	logic xfer_mode_enable;
	logic bit_request_ack;
	logic coord_clear_in;
	logic bit_ready;
	logic bit_value_out;
	logic xfer_error_flag;

	modport dev (
		input  xfer_mode_enable, bit_request_ack, coord_clear_in,
		output bit_ready, bit_value_out, xfer_error_flag
	);
	modport host (
		output xfer_mode_enable, bit_request_ack, coord_clear_in,
		input  bit_ready, bit_value_out, xfer_error_flag
	);
endinterface : aph_link_if

// [src/aph_cksum.sv]
// Frame checksum over status, turn count and pulse words
`timescale 1ns/1ps
module aph_cksum (
	// Frame words
	input  wire logic [15:0] w0,
	input  wire logic [15:0] w1,
	input  wire logic [15:0] w2,
	input  wire logic [15:0] w3,
	// Result
	output logic      [15:0] sum
);
	// Unsigned, every add wraps at 16 bits
	always_comb begin
		sum = (((((w0 + aph_pkg::CK_K0) ^ w1) + aph_pkg::CK_K1) ^ w2) + aph_pkg::CK_K2);
		sum = (sum ^ w3) + aph_pkg::CK_K3;
	end
endmodule : aph_cksum

// [src/aph_dev.sv]
// Drive end: serves the 80-bit absolute position frame over the handshake
// Function
// - Enable high, settle, then terminals become handshake
// - Host lowers request to ask next bit
// - Ready rises 7 to 15 ms after request
// - Host samples data, then raises acknowledge
// - Acknowledge held confirm time, ready falls
// - Ready low, host requests following bit
// - Ready high too long raises error, aborts
// - On error host cycles enable, restarts
// - Eighty bits, bit 0 first, bit 79 last
// - Status bits 15..0, turns bits 31..16
// - Pulse bits 63..32, checksum bits 79..64
// - Checksum words: status, turns, pulse halves
// - Chained add and xor checksum, unsigned
// - Host waits settle time before any step
// - Clear held prepare time zeroes pulse count
// - Writing one to init parameter resets coordinates
// - Data valid only while ready high
// - Handshake functions act only with enable
`timescale 1ns/1ps
module aph_dev #(
	parameter int unsigned SETTLE_CYC  = aph_pkg::SETTLE_CYC,
	parameter int unsigned PREP_CYC    = aph_pkg::PREP_CYC,
	parameter int unsigned CONFIRM_CYC = aph_pkg::CONFIRM_CYC,
	parameter int unsigned TIMEOUT_CYC = aph_pkg::TIMEOUT_CYC
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Link to host
	aph_link_if.dev          link,
	// Encoder position
	input  wire logic [15:0] encoder_status,
	input  wire logic [15:0] encoder_turn,
	input  wire logic [31:0] encoder_pulse,
	// Parameter write port
	input  wire logic        coord_init_wr,
	input  wire logic [15:0] coord_init_param,
	// Coordinate control
	output logic             coord_reset,
	output logic             position_lost_alarm
);
	if (SETTLE_CYC < 1 || PREP_CYC < 1 || CONFIRM_CYC < 1 || TIMEOUT_CYC < 1) begin : g_chk
		$error("aph_dev: cycle counts must be at least one");
	end

	typedef struct packed {
		aph_pkg::aph_dev_state_t st;
		logic        en_s1;
		logic        en_s2;
		logic        req_s1;
		logic        req_s2;
		logic        clr_s1;
		logic        clr_s2;
		logic [31:0] cnt;
		logic [31:0] clr_cnt;
		logic [6:0]  idx;
		logic [79:0] frame;
		logic        rdy;
		logic        dout;
		logic        err;
		logic        coord_reset;
		logic        lost;
	} aph_dev_t;

	localparam aph_dev_t RST = '{st: aph_pkg::D_IDLE, req_s1: 1'b1, req_s2: 1'b1,
		lost: 1'b1, default: '0};

	aph_dev_t    r_reg;
	aph_dev_t    r_next;
	logic [15:0] cksum;

	// Counters start at zero, so n cycles end on n - 1
	function automatic logic aph_at_count(input logic [31:0] c, input int unsigned n);
		return c == 32'(n - 1);
	endfunction : aph_at_count

	aph_cksum u_cksum (
		.w0  (encoder_status),
		.w1  (encoder_turn),
		.w2  (encoder_pulse[15:0]),
		.w3  (encoder_pulse[31:16]),
		.sum (cksum)
	);

	always_comb begin
		r_next = r_reg;
		r_next.coord_reset = 1'b0;
		// Link pins come from the far end: two flops each
		r_next.en_s1  = link.xfer_mode_enable;
		r_next.en_s2  = r_reg.en_s1;
		r_next.req_s1 = link.bit_request_ack;
		r_next.req_s2 = r_reg.req_s1;
		r_next.clr_s1 = link.coord_clear_in;
		r_next.clr_s2 = r_reg.clr_s1;
		r_next.cnt    = r_reg.cnt + 32'h1;
		case (r_reg.st)
			aph_pkg::D_IDLE: begin
				r_next.cnt = '0;
				if (r_reg.en_s2) begin
					r_next.st = aph_pkg::D_SETTLE;
				end
			end
			aph_pkg::D_SETTLE: begin
				if (aph_at_count(r_reg.cnt, SETTLE_CYC)) begin
					r_next.st = aph_pkg::D_WAIT;
					// Snapshot keeps the checksum consistent for the whole transfer
					r_next.frame[15:0]  = encoder_status;
					r_next.frame[31:16] = encoder_turn;
					r_next.frame[63:32] = encoder_pulse;
					r_next.frame[79:64] = cksum;
				end
			end
			aph_pkg::D_WAIT: begin
				r_next.cnt = '0;
				if (!r_reg.req_s2) begin
					r_next.st = aph_pkg::D_PREP;
				end
			end
			aph_pkg::D_PREP: begin
				if (aph_at_count(r_reg.cnt, PREP_CYC)) begin
					r_next.rdy  = 1'b1;
					r_next.dout = r_reg.frame[r_reg.idx];
					r_next.cnt  = '0;
					r_next.st   = aph_pkg::D_READY;
				end
			end
			aph_pkg::D_READY: begin
				if (r_reg.req_s2) begin
					r_next.cnt = '0;
					r_next.st  = aph_pkg::D_CONFIRM;
				end else if (aph_at_count(r_reg.cnt, TIMEOUT_CYC)) begin
					r_next.err = 1'b1;
					r_next.rdy = 1'b0;
					r_next.st  = aph_pkg::D_HOLD;
				end
			end
			aph_pkg::D_CONFIRM: begin
				// A glitch on acknowledge restarts both confirm and timeout
				if (!r_reg.req_s2) begin
					r_next.cnt = '0;
					r_next.st  = aph_pkg::D_READY;
				end else if (aph_at_count(r_reg.cnt, CONFIRM_CYC)) begin
					r_next.rdy = 1'b0;
					if (r_reg.idx == 7'(aph_pkg::FRAME_BITS - 1)) begin
						r_next.st = aph_pkg::D_HOLD;
					end else begin
						r_next.idx = r_reg.idx + 7'h01;
						r_next.st  = aph_pkg::D_WAIT;
					end
				end
			end
			aph_pkg::D_HOLD: begin
				// Last bit served or ready timed out; only enable low leaves here
				r_next.cnt = '0;
			end
			default: begin
				r_next.st = aph_pkg::D_IDLE;
			end
		endcase

		// Clear input honoured only once the handshake terminals are live
		if (r_reg.clr_s2 && r_reg.st != aph_pkg::D_IDLE && r_reg.st != aph_pkg::D_SETTLE) begin
			if (r_reg.clr_cnt != 32'(PREP_CYC)) begin
				r_next.clr_cnt = r_reg.clr_cnt + 32'h1;
			end
			if (aph_at_count(r_reg.clr_cnt, PREP_CYC)) begin
				r_next.coord_reset = 1'b1;
			end
		end else begin
			r_next.clr_cnt = '0;
		end
		if (coord_init_wr && coord_init_param == aph_pkg::COORD_INIT_VAL) begin
			r_next.coord_reset = 1'b1;
		end
		// Alarm stays up until coordinates are first set
		if (r_next.coord_reset) begin
			r_next.lost = 1'b0;
		end

		// Enable low overrides every state, aborting mid-bit
		if (!r_reg.en_s2) begin
			r_next.st  = aph_pkg::D_IDLE;
			r_next.err = 1'b0;
			r_next.rdy = 1'b0;
			r_next.idx = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= RST;
		end else begin
			r_reg <= r_next;
		end
	end

	// Data is left unchanged outside ready, host must ignore it then
	assign link.bit_ready       = r_reg.rdy;
	assign link.bit_value_out   = r_reg.dout;
	assign link.xfer_error_flag = r_reg.err;
	assign coord_reset          = r_reg.coord_reset;
	assign position_lost_alarm  = r_reg.lost;
endmodule : aph_dev

// [src/aph_host.sv]
// Host end: AXI4-Lite controlled reader and coordinate clearer
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module aph_host #(
	parameter int unsigned HSETTLE_CYC = aph_pkg::HSETTLE_CYC,
	parameter int unsigned HCLR_CYC    = aph_pkg::HCLR_CYC
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Link to drive
	aph_link_if.host         link,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	if (HSETTLE_CYC < 1 || HCLR_CYC < 1) begin : g_chk
		$error("aph_host: cycle counts must be at least one");
	end

	typedef struct packed {
		aph_pkg::aph_host_state_t st;
		logic        rdy_s1;
		logic        rdy_s2;
		logic        dat_s1;
		logic        dat_s2;
		logic        err_s1;
		logic        err_s2;
		logic [31:0] cnt;
		logic [6:0]  idx;
		logic [79:0] frame;
		logic        op_clr;
		logic        en;
		logic        req;
		logic        clr;
		logic        done;
		logic [7:0]  retries;
		logic        aw_got;
		logic [7:0]  aw_addr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} aph_host_t;

	localparam aph_host_t RST = '{st: aph_pkg::H_IDLE, req: 1'b1, awready: 1'b1,
		wready: 1'b1, arready: 1'b1, default: '0};

	aph_host_t r_reg;
	aph_host_t r_next;

	function automatic logic aph_reg_ok(input logic [7:0] a);
		aph_reg_ok = a == aph_pkg::REG_CTRL || a == aph_pkg::REG_STAT ||
			a == aph_pkg::REG_DATA0 || a == aph_pkg::REG_DATA1 || a == aph_pkg::REG_DATA2;
	endfunction : aph_reg_ok

	always_comb begin
		r_next = r_reg;
		r_next.rdy_s1 = link.bit_ready;
		r_next.rdy_s2 = r_reg.rdy_s1;
		r_next.dat_s1 = link.bit_value_out;
		r_next.dat_s2 = r_reg.dat_s1;
		r_next.err_s1 = link.xfer_error_flag;
		r_next.err_s2 = r_reg.err_s1;
		r_next.cnt    = r_reg.cnt + 32'h1;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && r_reg.awready) begin
			r_next.aw_got  = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && r_reg.wready) begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready) begin
			r_next.bvalid = 1'b0;
		end
		if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = aph_reg_ok(r_reg.aw_addr) ? aph_pkg::RESP_OKAY : aph_pkg::RESP_SLVERR;
			// Commands while busy are dropped, not queued
			if (r_reg.aw_addr == aph_pkg::REG_CTRL && r_reg.wstrb[0] &&
				r_reg.st == aph_pkg::H_IDLE &&
				(r_reg.wdata[aph_pkg::CTRL_READ] || r_reg.wdata[aph_pkg::CTRL_CLEAR])) begin
				r_next.op_clr  = !r_reg.wdata[aph_pkg::CTRL_READ];
				r_next.en      = 1'b1;
				r_next.done    = 1'b0;
				r_next.retries = '0;
				r_next.idx     = '0;
				r_next.cnt     = '0;
				r_next.st      = aph_pkg::H_SETTLE;
			end
		end

		// Read channel
		if (r_reg.rvalid && s_axi_rready) begin
			r_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r_reg.arready) begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = aph_reg_ok(s_axi_araddr) ? aph_pkg::RESP_OKAY : aph_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				aph_pkg::REG_STAT:  r_next.rdata = {16'h0000, r_reg.retries, 5'h00,
					r_reg.err_s2, r_reg.done, r_reg.st != aph_pkg::H_IDLE};
				aph_pkg::REG_DATA0: r_next.rdata = r_reg.frame[31:0];
				aph_pkg::REG_DATA1: r_next.rdata = r_reg.frame[63:32];
				aph_pkg::REG_DATA2: r_next.rdata = {16'h0000, r_reg.frame[79:64]};
				default:            r_next.rdata = 32'h0000_0000;
			endcase
		end

		case (r_reg.st)
			aph_pkg::H_IDLE: begin
				r_next.cnt = '0;
			end
			aph_pkg::H_SETTLE: begin
				if (r_reg.cnt == 32'(HSETTLE_CYC - 1)) begin
					r_next.cnt = '0;
					if (r_reg.op_clr) begin
						r_next.clr = 1'b1;
						r_next.st  = aph_pkg::H_CLEAR;
					end else begin
						r_next.req = 1'b0;
						r_next.st  = aph_pkg::H_REQ;
					end
				end
			end
			aph_pkg::H_REQ: begin
				if (r_reg.rdy_s2) begin
					r_next.frame[r_reg.idx] = r_reg.dat_s2;
					r_next.req = 1'b1;
					r_next.st  = aph_pkg::H_WAITLOW;
				end
			end
			aph_pkg::H_WAITLOW: begin
				if (!r_reg.rdy_s2) begin
					if (r_reg.idx == 7'(aph_pkg::FRAME_BITS - 1)) begin
						r_next.en   = 1'b0;
						r_next.done = 1'b1;
						r_next.st   = aph_pkg::H_IDLE;
					end else begin
						r_next.idx = r_reg.idx + 7'h01;
						r_next.req = 1'b0;
						r_next.st  = aph_pkg::H_REQ;
					end
				end
			end
			aph_pkg::H_CLEAR: begin
				if (r_reg.cnt == 32'(HCLR_CYC - 1)) begin
					r_next.clr  = 1'b0;
					r_next.en   = 1'b0;
					r_next.done = 1'b1;
					r_next.st   = aph_pkg::H_IDLE;
				end
			end
			aph_pkg::H_DROP: begin
				if (r_reg.cnt == 32'(aph_pkg::DROP_CYC - 1)) begin
					r_next.en  = 1'b1;
					r_next.idx = '0;
					r_next.cnt = '0;
					r_next.st  = aph_pkg::H_SETTLE;
				end
			end
			default: begin
				r_next.st = aph_pkg::H_IDLE;
			end
		endcase

		if (r_reg.err_s2 && (r_reg.st == aph_pkg::H_REQ || r_reg.st == aph_pkg::H_WAITLOW)) begin
			r_next.en      = 1'b0;
			r_next.req     = 1'b1;
			r_next.cnt     = '0;
			r_next.retries = r_reg.retries + 8'h01;
			r_next.st      = aph_pkg::H_DROP;
		end

		r_next.awready = !r_next.aw_got && !r_next.bvalid;
		r_next.wready  = !r_next.w_got && !r_next.bvalid;
		r_next.arready = !r_next.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_reg <= RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign link.xfer_mode_enable = r_reg.en;
	assign link.bit_request_ack  = r_reg.req;
	assign link.coord_clear_in   = r_reg.clr;
	assign s_axi_awready         = r_reg.awready;
	assign s_axi_wready          = r_reg.wready;
	assign s_axi_bvalid          = r_reg.bvalid;
	assign s_axi_bresp           = r_reg.bresp;
	assign s_axi_arready         = r_reg.arready;
	assign s_axi_rvalid          = r_reg.rvalid;
	assign s_axi_rdata           = r_reg.rdata;
	assign s_axi_rresp           = r_reg.rresp;
endmodule : aph_host

// [verification/aph_link_asserts.sv]
// Concurrent checks on the handshake link between host end and drive end
`timescale 1ns/1ps
module aph_link_asserts #(
	parameter int SETTLE_CYC  = 20,
	parameter int PREP_CYC    = 10,
	parameter int CONFIRM_CYC = 4
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link wires
	input wire logic xfer_mode_enable,
	input wire logic bit_request_ack,
	input wire logic coord_clear_in,
	input wire logic bit_ready,
	input wire logic bit_value_out,
	input wire logic xfer_error_flag
);
	logic [31:0] en_cnt_reg;
	logic [31:0] lo_cnt_reg;
	logic [31:0] ack_cnt_reg;
	logic [31:0] clr_cnt_reg;
	logic [7:0]  bit_cnt_reg;
	logic        rdy_q_reg;

	// Counters restart with every session
	always_ff @(posedge aclk) begin
		if (!aresetn || !xfer_mode_enable) begin
			en_cnt_reg  <= '0;
			lo_cnt_reg  <= '0;
			ack_cnt_reg <= '0;
			clr_cnt_reg <= '0;
			bit_cnt_reg <= '0;
			rdy_q_reg   <= 1'b0;
		end else begin
			en_cnt_reg  <= en_cnt_reg + 32'h1;
			lo_cnt_reg  <= bit_request_ack ? 32'h0 : lo_cnt_reg + 32'h1;
			ack_cnt_reg <= (bit_ready && bit_request_ack) ? ack_cnt_reg + 32'h1 : 32'h0;
			clr_cnt_reg <= coord_clear_in ? clr_cnt_reg + 32'h1 : 32'h0;
			bit_cnt_reg <= bit_cnt_reg + 8'((bit_ready && !rdy_q_reg) ? 1 : 0);
			rdy_q_reg   <= bit_ready;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	ready_prep_a: assert property ($rose(bit_ready) |->
		lo_cnt_reg >= PREP_CYC + 1 && lo_cnt_reg <= PREP_CYC + 5)
		else $error("ready rose outside the prepare window");
	ready_confirm_a: assert property ($fell(bit_ready) && !xfer_error_flag |->
		ack_cnt_reg >= CONFIRM_CYC + 2 && ack_cnt_reg <= CONFIRM_CYC + 5)
		else $error("ready fell outside the confirm window");
	data_stable_a: assert property (bit_ready && $past(bit_ready) |->
		$stable(bit_value_out)) else $error("data moved while ready high");
	ready_gap_a: assert property ($fell(bit_ready) |-> !bit_ready [*8])
		else $error("ready came back too soon");
	req_first_a: assert property ($rose(bit_ready) |-> !bit_request_ack &&
		en_cnt_reg > SETTLE_CYC + PREP_CYC) else $error("ready without settled request");
	bit_limit_a: assert property ($rose(bit_ready) |-> bit_cnt_reg < 8'd80)
		else $error("more than eighty bits served");
	frame_end_a: assert property ($fell(xfer_mode_enable) |->
		bit_cnt_reg == 8'd80 || bit_cnt_reg == 8'd0) else $error("session ended mid frame");
	clr_settle_a: assert property ($rose(coord_clear_in) |-> en_cnt_reg >= SETTLE_CYC)
		else $error("clear raised before settle");
	clr_hold_a: assert property ($fell(coord_clear_in) |-> clr_cnt_reg >= PREP_CYC)
		else $error("clear held too briefly");

	cover property ($rose(bit_ready));
	cover property ($fell(coord_clear_in));
	cover property ($fell(xfer_mode_enable) && bit_cnt_reg == 8'd80);
endmodule : aph_link_asserts

// [verification/absolute_position_handshake_readout_tb.sv]
// Bench joining host and drive ends, plus a drive end under direct bench control
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module absolute_position_handshake_readout_tb;
	localparam int SC = 20;
	localparam int PC = 10;
	localparam int CC = 4;
	localparam int TC = 200;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [15:0] stat = '0, turn = '0, cinit_val = '0;
	logic [31:0] pulse = '0, wdata = '0, rdata, d, lfsr_state = 32'h25967006;
	logic [7:0]  awaddr = '0, araddr = '0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        cinit_wr = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic        crst1, crst2, alarm1, alarm2;
	logic [1:0]  bresp, rresp, r;
	logic [79:0] f;
	int          miscompares = 0, samples_checked = 0, cyc = 0, crs1 = 0, crs2 = 0, n;

	aph_link_if link ();
	aph_link_if link2 ();
	aph_host #(.HSETTLE_CYC(30), .HCLR_CYC(20)) u_aph_host (
		.aclk(aclk), .aresetn(aresetn), .link(link),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	aph_dev #(.SETTLE_CYC(SC), .PREP_CYC(PC), .CONFIRM_CYC(CC), .TIMEOUT_CYC(TC)) u_aph_dev (
		.aclk(aclk), .aresetn(aresetn), .link(link), .encoder_status(stat),
		.encoder_turn(turn), .encoder_pulse(pulse), .coord_init_wr(1'b0),
		.coord_init_param(16'h0000), .coord_reset(crst1), .position_lost_alarm(alarm1));
	// Second drive end lets the bench break the host side on purpose
	aph_dev #(.SETTLE_CYC(SC), .PREP_CYC(PC), .CONFIRM_CYC(CC), .TIMEOUT_CYC(TC)) u_aph_dev_2 (
		.aclk(aclk), .aresetn(aresetn), .link(link2), .encoder_status(stat),
		.encoder_turn(turn), .encoder_pulse(pulse), .coord_init_wr(cinit_wr),
		.coord_init_param(cinit_val), .coord_reset(crst2), .position_lost_alarm(alarm2));
	aph_link_asserts #(.SETTLE_CYC(SC), .PREP_CYC(PC), .CONFIRM_CYC(CC)) u_aph_link_asserts (
		.aclk(aclk), .aresetn(aresetn), .xfer_mode_enable(link.xfer_mode_enable),
		.bit_request_ack(link.bit_request_ack), .coord_clear_in(link.coord_clear_in),
		.bit_ready(link.bit_ready), .bit_value_out(link.bit_value_out),
		.xfer_error_flag(link.xfer_error_flag));

	always #10 aclk = ~aclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr

	function automatic logic [79:0] frame(input logic [15:0] s, t, input logic [31:0] p);
		logic [15:0] c;
		c = ((((((s + 16'hA700) ^ t) + 16'h605A) ^ p[15:0]) + 16'h30A5) ^ p[31:16]) + 16'h5A06;
		return {c, p, t, s};
	endfunction : frame

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim

	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK("bresp", aph_pkg::RESP_OKAY, bresp)
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : axr

	always @(posedge aclk) begin
		cyc++;
		crs1 += int'(crst1);
		crs2 += int'(crst2);
		if (cyc == 40000) begin
			miscompares++;
			end_sim();
		end
	end

	initial begin
		link2.xfer_mode_enable = 1'b0;
		link2.bit_request_ack = 1'b1;
		link2.coord_clear_in = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK("alarm1", 1'b1, alarm1)
		axr(aph_pkg::REG_STAT);
		`CHK("stat", 32'h0, d)
		axr(8'h20);
		`CHK("bad resp", aph_pkg::RESP_SLVERR, r)
		`CHK("bad data", 32'h0, d)
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			lfsr_state = lfsr(lfsr_state);
			f = frame(i == 0 ? 16'hFFFF : lfsr_state[15:0],
				i == 0 ? 16'h8000 : i == 1 ? 16'h7FFF : lfsr_state[31:16],
				i == 1 ? 32'h00400000 : lfsr(lfsr_state) & 32'h003F_FFFF);
			stat <= f[15:0];
			turn <= f[31:16];
			pulse <= f[63:32];
			axw(aph_pkg::REG_CTRL, i == 2 ? 32'h3 : 32'h1);
			// Clear request while busy must be dropped
			if (i == 0) axw(aph_pkg::REG_CTRL, 32'h2);
			do axr(aph_pkg::REG_STAT); while (d[1] !== 1'b1);
			`CHK("status", 3'b010, d[2:0])
			`CHK("retries", 8'h00, d[15:8])
			axr(aph_pkg::REG_DATA0);
			`CHK("data0", f[31:0], d)
			axr(aph_pkg::REG_DATA1);
			`CHK("data1", f[63:32], d)
			axr(aph_pkg::REG_DATA2);
			`CHK("data2", f[79:64], d[15:0])
			$display("test frame %0d done", i);
		end
		`CHK("clears", 0, crs1)
		axw(aph_pkg::REG_CTRL, 32'h2);
		do axr(aph_pkg::REG_STAT); while (d[1] !== 1'b1);
		`CHK("clears", 1, crs1)
		`CHK("alarm1", 1'b0, alarm1)
		$display("test clear done");
		@(posedge aclk);
		cinit_val <= 16'h0002;
		cinit_wr <= 1'b1;
		@(posedge aclk);
		cinit_wr <= 1'b0;
		repeat (3) @(posedge aclk);
		`CHK("init other", 0, crs2)
		cinit_val <= 16'h0001;
		cinit_wr <= 1'b1;
		@(posedge aclk);
		cinit_wr <= 1'b0;
		#1;
		`CHK("init pulse", 1'b1, crst2)
		`CHK("alarm2", 1'b0, alarm2)
		@(posedge aclk);
		link2.bit_request_ack <= 1'b0;
		link2.coord_clear_in <= 1'b1;
		repeat (40) @(posedge aclk);
		`CHK("ready off", 1'b0, link2.bit_ready)
		`CHK("clear off", 1, crs2)
		link2.bit_request_ack <= 1'b1;
		link2.coord_clear_in <= 1'b0;
		link2.xfer_mode_enable <= 1'b1;
		repeat (SC + 8) @(posedge aclk);
		link2.bit_request_ack <= 1'b0;
		n = 0;
		while (link2.bit_ready !== 1'b1 && n < 40) begin
			@(posedge aclk);
			n++;
		end
		`CHK("prep", 1'b1, n >= PC + 2 && n <= PC + 5)
		`CHK("bit0", stat[0], link2.bit_value_out)
		n = 0;
		while (link2.xfer_error_flag !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		`CHK("timeout", 1'b1, n >= TC && n <= TC + 3)
		`CHK("abort", 1'b0, link2.bit_ready)
		link2.xfer_mode_enable <= 1'b0;
		repeat (4) @(posedge aclk);
		`CHK("err clear", 1'b0, link2.xfer_error_flag)
		$display("test timeout done");
		end_sim();
	end
endmodule : absolute_position_handshake_readout_tb
